// [src/key_function_pkg.sv]
// Constants, types and the default key table of the key function translator.
// Assumes one 100 MHz clock; key events come from a scanner on the same clock.
//
// Notes on behaviour
// - Each key owns a 16-bit entry; high byte picks page, low byte function.
// - Exactly thirty-two media functions, entries 0x0100 to 0x011F.
// - Each media entry sends its fixed consumer usage code.
// - Macro page entry runs macro number low byte; 32 bytes, first byte mode.
// - Mode zero is static: up to 31 codes, first zero code ends it.
// - Static macro presses its modifiers and up to six key codes in one report, releases them together.
// - Mode one is typing: up to 31 codes ending at first zero code.
// - Typing macro taps each ordinary key: press report, then release report.
// - Typing codes E0-E7 hold a modifier until matching break E8-EF.
// - Releasing the typing macro key drops every modifier it still holds.
// - Mode two is roll; byte two is timeout in 100 ms, zero expires at once.
// - First roll press sends first stored code, then a left arrow.
// - Roll timeout expiry sends a right arrow; last character stays.
// - Another roll key before timeout sends right arrow, then starts anew.
// - Same roll key within timeout sends delete forward, next code, left arrow.
// - A zero next code wraps the roll index back to the first code.
// - Mouse entries 0x0300-0x0303 move right, left, down, up while held.
// - Mouse entries 0x0310-0x0317 drive the eight mouse buttons in order.
// - Cursor steps grow along an acceleration curve while movement is held.
// - High byte E0-E7 reports that modifier with the low byte key together.
// - A preloaded default key table exists and may be overwritten.

package key_function_pkg;

  // ==========================================================
  // Timing
  localparam int CLOCK_HZ           = 100_000_000;
  localparam int ROLL_TICK_MS       = 100;
  localparam int ROLL_TICK_CYCLES   = CLOCK_HZ / 1000 * ROLL_TICK_MS;
  localparam int MOVE_PERIOD_MS     = 10;
  localparam int MOVE_PERIOD_CYCLES = CLOCK_HZ / 1000 * MOVE_PERIOD_MS;

  // ==========================================================
  // Sizes
  localparam int KEY_COUNT   = 64;
  localparam int MACRO_COUNT = 19;
  localparam int MACRO_BYTES = 32;
  localparam int REPORT_KEYS = 6;
  localparam int MEDIA_COUNT = 32;

  // ==========================================================
  // Pages, modes and codes
  localparam logic [7:0] PAGE_STD       = 8'h00;
  localparam logic [7:0] PAGE_MEDIA     = 8'h01;
  localparam logic [7:0] PAGE_MACRO     = 8'h02;
  localparam logic [7:0] PAGE_MOUSE     = 8'h03;
  localparam logic [7:0] MODE_STATIC    = 8'h00;
  localparam logic [7:0] MODE_TYPING    = 8'h01;
  localparam logic [7:0] MODE_ROLL      = 8'h02;
  localparam logic [4:0] MACRO_MODE_IDX = 5'h00;
  localparam logic [4:0] MACRO_FIRST    = 5'h01;
  localparam logic [4:0] ROLL_TIME_IDX  = 5'h01;
  localparam logic [4:0] ROLL_FIRST     = 5'h02;
  localparam logic [4:0] ROLL_LAST_SEQ  = 5'h1D;
  localparam logic [4:0] MOD_PRESS_TOP  = 5'h1C;
  localparam logic [4:0] MOD_BREAK_TOP  = 5'h1D;
  localparam logic [7:0] STD_FIRST      = 8'h04;
  localparam logic [7:0] STD_LAST       = 8'hDD;
  localparam logic [7:0] ARROW_LEFT     = 8'h50;
  localparam logic [7:0] ARROW_RIGHT    = 8'h4F;
  localparam logic [7:0] DELETE_FWD     = 8'h4C;
  localparam logic [7:0] MOVE_LAST      = 8'h03;
  localparam logic [4:0] BUTTON_TOP     = 5'h02;

  localparam logic [7:0] ACCEL_START = 8'h01;
  localparam logic [7:0] ACCEL_MAX   = 8'h20;

  localparam logic [15:0] MEDIA_USAGE [MEDIA_COUNT] = '{
    16'h00B0, 16'h00B1, 16'h00B2, 16'h00B3, 16'h00B4, 16'h00B5, 16'h00B6, 16'h00B7,
    16'h00B8, 16'h00B9, 16'h00CC, 16'h00CD, 16'h00E2, 16'h00E9, 16'h00EA, 16'h0184,
    16'h0185, 16'h0186, 16'h0187, 16'h0188, 16'h0189, 16'h018A, 16'h018B, 16'h018C,
    16'h018D, 16'h018E, 16'h0192, 16'h0194, 16'h0196, 16'h01A0, 16'h01A6, 16'h021F};

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] func;
  } entry_t;

  typedef enum logic [1:0] {RPT_KEYBOARD, RPT_CONSUMER, RPT_MOUSE} report_kind_t;

  typedef struct packed {
    report_kind_t                    kind;
    logic [7:0]                      modifiers;
    logic [REPORT_KEYS-1:0][7:0]     keys;
    logic [15:0]                     usage;
    logic [7:0]                      buttons;
    logic [7:0]                      dx;
    logic [7:0]                      dy;
  } hid_report_t;

  typedef struct packed {
    logic       press;
    logic [5:0] index;
  } key_event_t;

  typedef struct packed {
    logic [5:0] index;
    entry_t     entry;
  } table_write_t;

  typedef struct packed {
    logic [4:0] macro;
    logic [4:0] offset;
    logic [7:0] data;
  } macro_write_t;

  // Factory layout: letters a-z, then digits 1-0, rest unassigned
  function automatic entry_t default_entry(input int idx);
    entry_t e;
    e.page = PAGE_STD;
    if (idx < 26) e.func = 8'(8'h04 + idx);
    else if (idx < 36) e.func = 8'(8'h1E + idx - 26);
    else e.func = 8'h00;
    return e;
  endfunction

endpackage

// [src/mouse_accel.sv]
// Cursor acceleration: movement tick and a step that grows while held.
// Assumes a same-clock level that is high while any move key is held.
`timescale 1ns/1ps
module mouse_accel #(
  parameter int PERIOD = key_function_pkg::MOVE_PERIOD_CYCLES
) (
  input  wire logic       clock,    // System clock
  input  wire logic       rst_n,    // Asynchronous reset, active low
  input  wire logic       moving,   // Any move direction held
  output logic            moveTick, // One-cycle pulse per movement step
  output logic [7:0]      step      // Current step size
);
  import key_function_pkg::*;

  logic [31:0] periodCnt;
  wire         periodEnd = (periodCnt == 32'(PERIOD - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      periodCnt <= '0;
      moveTick  <= 1'b0;
      step      <= ACCEL_START;
    end else begin
      moveTick  <= moving && periodEnd;
      periodCnt <= (!moving || periodEnd) ? '0 : periodCnt + 32'd1;
      if (!moving) begin
        step <= ACCEL_START;
      end else if (moveTick && step != ACCEL_MAX) begin
        step <= step + 8'h01;
      end
    end
  end
endmodule

// [src/key_function_translator.sv]
// Translates per-key table entries into keyboard, consumer and mouse reports.
// Assumes debounced key events from the scanner and a report sink with ready.
`timescale 1ns/1ps
module key_function_translator #(
  parameter int TICK_CYCLES = key_function_pkg::ROLL_TICK_CYCLES,
  parameter int MOVE_CYCLES = key_function_pkg::MOVE_PERIOD_CYCLES
) (
  input  wire logic                          clock,       // System clock
  input  wire logic                          rst_n,       // Asynchronous reset
  input  wire key_function_pkg::key_event_t  keyEvent,    // Key press or release
  input  wire logic                          keyValid,    // Key event offered
  output logic                               keyReady,    // Key event taken
  input  wire logic                          tableWe,     // Write one table entry
  input  wire key_function_pkg::table_write_t tableWrite, // Entry and index
  input  wire logic                          macroWe,     // Write one macro byte
  input  wire key_function_pkg::macro_write_t macroWrite, // Macro byte and place
  output key_function_pkg::hid_report_t      report,      // Report to host
  output logic                               reportValid, // Report offered
  input  wire logic                          reportReady  // Host accepts report
);
  import key_function_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_STATIC, ST_TYPE, ST_OPS, ST_TAP_UP, ST_SEND} state_t;

  // ==========================================================
  // Storage
  entry_t     keyTable [KEY_COUNT];
  logic [7:0] macroMem [MACRO_COUNT*MACRO_BYTES];

  for (genvar i = 0; i < KEY_COUNT; i++) begin : g_table
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        keyTable[i] <= default_entry(i);
      end else if (tableWe && tableWrite.index == 6'(i)) begin
        keyTable[i] <= tableWrite.entry;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int j = 0; j < MACRO_COUNT*MACRO_BYTES; j++) macroMem[j] <= 8'h00;
    end else if (macroWe && macroWrite.macro < 5'(MACRO_COUNT)) begin
      macroMem[{macroWrite.macro, macroWrite.offset}] <= macroWrite.data;
    end
  end

  // ==========================================================
  // State
  state_t      state, retState, tapRet;
  logic [7:0]  slot [REPORT_KEYS];
  logic [7:0]  heldMods, macroMods, tapKey, buttons;
  logic [15:0] usage;
  logic [3:0]  moveHeld;
  logic [4:0]  walkIdx, walkMacro;
  logic        walkPress;
  report_kind_t sendKind;
  logic [7:0]  opList [3];
  logic [1:0]  opCount, opIdx;
  logic        rollActive;
  logic [5:0]  rollKey;
  logic [4:0]  rollMacro, rollSeq;
  logic [7:0]  rollCount;
  logic [31:0] tickCnt;

  // ==========================================================
  // Decode
  wire         take      = keyValid && keyReady;
  entry_t      entry;
  assign entry = keyTable[keyEvent.index];
  wire         isCombo   = entry.page[7:3] == MOD_PRESS_TOP;
  wire [4:0]   newMacro  = entry.func[4:0];
  wire         macroOk   = entry.func < 8'(MACRO_COUNT);
  wire [7:0]   modeByte  = macroMem[{newMacro, MACRO_MODE_IDX}];
  wire [7:0]   timeByte  = macroMem[{newMacro, ROLL_TIME_IDX}];
  wire [7:0]   firstCode = macroMem[{newMacro, ROLL_FIRST}];
  wire [7:0]   walkByte  = macroMem[{walkMacro, walkIdx}];
  wire [7:0]   rollTime  = macroMem[{rollMacro, ROLL_TIME_IDX}];
  wire [4:0]   rawSeq    = rollSeq + 5'd1;
  wire [7:0]   rawCode   = macroMem[{rollMacro, rawSeq + ROLL_FIRST}];
  wire [4:0]   nextSeq   = (rollSeq == ROLL_LAST_SEQ || rawCode == 8'h00) ? 5'd0 : rawSeq;
  wire [7:0]   nextCode  = macroMem[{rollMacro, nextSeq + ROLL_FIRST}];
  wire         sameRoll  = rollActive && rollKey == keyEvent.index;
  wire         rollTick  = tickCnt == 32'(TICK_CYCLES - 1);
  wire         rollExpire = rollActive && rollCount == 8'h00;
  wire         moveTick;
  wire [7:0]   moveStep;

  // Code under edit: macro byte while walking a static macro, else the entry's low byte
  wire [7:0]   editCode  = (state == ST_STATIC) ? walkByte : entry.func;
  wire         editAdd   = (state == ST_STATIC) ? walkPress : keyEvent.press;
  wire         editIsMod = editCode[7:3] == MOD_PRESS_TOP;
  wire [7:0]   editMask  = 8'h01 << editCode[2:0];
  wire [7:0]   next_mods = editAdd ? (heldMods | editMask) : (heldMods & ~editMask);
  wire [7:0]   comboMask = 8'h01 << entry.page[2:0];
  wire [7:0]   walkMask  = 8'h01 << walkByte[2:0];
  wire [7:0]   buttonMask = 8'h01 << entry.func[2:0];

  logic [7:0] next_slot [REPORT_KEYS];
  always_comb begin
    logic placed;
    logic present;
    placed  = 1'b0;
    present = 1'b0;
    for (int i = 0; i < REPORT_KEYS; i++) present = present || slot[i] == editCode;
    for (int i = 0; i < REPORT_KEYS; i++) begin
      next_slot[i] = slot[i];
      if (!editAdd && slot[i] == editCode) next_slot[i] = 8'h00;
      if (editAdd && !present && !placed && slot[i] == 8'h00) begin
        next_slot[i] = editCode;
        placed       = 1'b1;
      end
    end
  end

  // Report as it stands; a tapped key takes the last key position
  hid_report_t composed;
  always_comb begin
    composed           = '0;
    composed.kind      = sendKind;
    composed.modifiers = heldMods | macroMods;
    for (int i = 0; i < REPORT_KEYS; i++) composed.keys[i] = slot[i];
    if (tapKey != 8'h00) composed.keys[REPORT_KEYS-1] = tapKey;
    composed.usage     = usage;
    composed.buttons   = buttons;
    composed.dx = moveHeld[0] ? moveStep : moveHeld[1] ? 8'(-moveStep) : 8'h00;
    composed.dy = moveHeld[2] ? moveStep : moveHeld[3] ? 8'(-moveStep) : 8'h00;
  end

  mouse_accel #(.PERIOD(MOVE_CYCLES)) u_accel (
    .clock    (clock),
    .rst_n    (rst_n),
    .moving   (moveHeld != 4'h0),
    .moveTick (moveTick),
    .step     (moveStep)
  );

  // ==========================================================
  // Sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;       retState <= ST_IDLE;   tapRet <= ST_IDLE;
      for (int i = 0; i < REPORT_KEYS; i++) slot[i] <= 8'h00;
      for (int i = 0; i < 3; i++) opList[i] <= 8'h00;
      heldMods <= 8'h00;      macroMods <= 8'h00;    tapKey <= 8'h00;
      buttons <= 8'h00;       usage <= 16'h0000;     moveHeld <= 4'h0;
      walkIdx <= 5'h00;       walkMacro <= 5'h00;    walkPress <= 1'b0;
      sendKind <= RPT_KEYBOARD; opCount <= 2'd0;     opIdx <= 2'd0;
      rollActive <= 1'b0;     rollKey <= 6'h00;      rollMacro <= 5'h00;
      rollSeq <= 5'h00;       rollCount <= 8'h00;    tickCnt <= '0;
      keyReady <= 1'b0;       reportValid <= 1'b0;   report <= '0;
    end else begin
      tickCnt  <= rollTick ? '0 : tickCnt + 32'd1;
      keyReady <= 1'b0;
      if (rollTick && rollActive && rollCount != 8'h00) rollCount <= rollCount - 8'h01;
      unique case (state)
        ST_IDLE: begin
          if (take) begin
            state    <= ST_SEND;
            retState <= ST_IDLE;
            sendKind <= RPT_KEYBOARD;
            if (entry.page == PAGE_STD) begin
              if (editIsMod) heldMods <= next_mods;
              else if (entry.func >= STD_FIRST && entry.func <= STD_LAST) slot <= next_slot;
            end else if (isCombo) begin
              heldMods <= keyEvent.press ? (heldMods | comboMask) : (heldMods & ~comboMask);
              slot     <= next_slot;
            end else if (entry.page == PAGE_MEDIA && entry.func < 8'(MEDIA_COUNT)) begin
              usage    <= keyEvent.press ? MEDIA_USAGE[entry.func[4:0]] : 16'h0000;
              sendKind <= RPT_CONSUMER;
            end else if (entry.page == PAGE_MOUSE && entry.func <= MOVE_LAST) begin
              moveHeld[entry.func[1:0]] <= keyEvent.press;
              state    <= ST_IDLE;
            end else if (entry.page == PAGE_MOUSE && entry.func[7:3] == BUTTON_TOP) begin
              buttons  <= keyEvent.press ? (buttons | buttonMask) : (buttons & ~buttonMask);
              sendKind <= RPT_MOUSE;
            end else if (entry.page == PAGE_MACRO && macroOk && modeByte == MODE_STATIC) begin
              walkMacro <= newMacro;
              walkIdx   <= MACRO_FIRST;
              walkPress <= keyEvent.press;
              state     <= ST_STATIC;
            end else if (entry.page == PAGE_MACRO && macroOk && modeByte == MODE_TYPING) begin
              walkMacro <= newMacro;
              walkIdx   <= MACRO_FIRST;
              if (keyEvent.press) state <= ST_TYPE;
              else macroMods <= 8'h00;
            end else if (entry.page == PAGE_MACRO && macroOk && modeByte == MODE_ROLL
                         && keyEvent.press) begin
              state <= ST_OPS;
              opIdx <= 2'd0;
              if (sameRoll) begin
                opList[0] <= DELETE_FWD;
                opList[1] <= nextCode;
                opList[2] <= ARROW_LEFT;
                opCount   <= 2'd3;
                rollSeq   <= nextSeq;
                rollCount <= rollTime;
              end else begin
                opList[0] <= rollActive ? ARROW_RIGHT : firstCode;
                opList[1] <= rollActive ? firstCode : ARROW_LEFT;
                opList[2] <= ARROW_LEFT;
                opCount   <= rollActive ? 2'd3 : 2'd2;
                rollSeq   <= 5'h00;
                rollCount <= timeByte;
                rollMacro <= newMacro;
                rollKey   <= keyEvent.index;
              end
              rollActive <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end else if (rollExpire) begin
            opList[0]  <= ARROW_RIGHT;
            opCount    <= 2'd1;
            opIdx      <= 2'd0;
            rollActive <= 1'b0;
            state      <= ST_OPS;
          end else if (moveTick) begin
            sendKind <= RPT_MOUSE;
            retState <= ST_IDLE;
            state    <= ST_SEND;
          end else begin
            keyReady <= 1'b1;
          end
        end
        ST_STATIC: begin
          if (walkIdx == 5'h00 || walkByte == 8'h00) begin
            state <= ST_SEND;
          end else begin
            if (walkByte[7:3] == MOD_PRESS_TOP) heldMods <= next_mods;
            else slot <= next_slot;
            walkIdx <= walkIdx + 5'd1;
          end
        end
        ST_TYPE: begin
          retState <= ST_TYPE;
          walkIdx  <= walkIdx + 5'd1;
          if (walkIdx == 5'h00 || walkByte == 8'h00) begin
            state <= ST_IDLE;
          end else if (walkByte[7:3] == MOD_PRESS_TOP) begin
            macroMods <= macroMods | walkMask;
            state     <= ST_SEND;
          end else if (walkByte[7:3] == MOD_BREAK_TOP) begin
            macroMods <= macroMods & ~walkMask;
            state     <= ST_SEND;
          end else begin
            tapKey   <= walkByte;
            tapRet   <= ST_TYPE;
            retState <= ST_TAP_UP;
            state    <= ST_SEND;
          end
        end
        ST_OPS: begin
          if (opIdx < opCount) begin
            tapKey   <= opList[opIdx];
            opIdx    <= opIdx + 2'd1;
            tapRet   <= ST_OPS;
            retState <= ST_TAP_UP;
            state    <= ST_SEND;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_TAP_UP: begin
          tapKey   <= 8'h00;
          retState <= tapRet;
          state    <= ST_SEND;
        end
        ST_SEND: begin
          if (!reportValid) begin
            report      <= composed;
            reportValid <= 1'b1;
          end else if (reportReady) begin
            reportValid <= 1'b0;
            sendKind    <= RPT_KEYBOARD;
            state       <= retState;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  report_hold_a: assert property (reportValid && !reportReady |=> reportValid && $stable(report))
    else $error("report changed before acceptance");
  take_idle_a: assert property (keyReady |-> state == ST_IDLE && !reportValid)
    else $error("key taken while busy");
  media_usage_a: assert property (take && entry.page == PAGE_MEDIA && entry.func < 8'h20
      && keyEvent.press |=> usage == MEDIA_USAGE[$past(entry.func[4:0])])
    else $error("media usage mismatch");
  roll_expire_a: assert property (state == ST_IDLE && !take && rollExpire
      |=> state == ST_OPS && opList[0] == ARROW_RIGHT && !rollActive)
    else $error("roll timeout did not send right arrow");
  typing_release_a: assert property (take && !keyEvent.press && entry.page == PAGE_MACRO
      && macroOk && modeByte == MODE_TYPING |=> macroMods == 8'h00)
    else $error("typing modifiers not released");
  tap_break_a: assert property (state == ST_TAP_UP |=> tapKey == 8'h00 ##1 reportValid)
    else $error("tapped key not released");
  roll_restart_a: assert property (take && keyEvent.press && sameRoll && entry.page == PAGE_MACRO
      && macroOk && modeByte == MODE_ROLL |=> rollCount == $past(rollTime))
    else $error("roll timeout not restarted");
  roll_wrap_a: assert property (rollActive && rawCode == 8'h00 |-> nextSeq == 5'h00)
    else $error("roll index did not wrap");
  button_map_a: assert property (take && keyEvent.press && entry.page == PAGE_MOUSE
      && entry.func[7:3] == BUTTON_TOP |=> buttons[$past(entry.func[2:0])])
    else $error("mouse button not set");

  static_cover_c: cover property (state == ST_STATIC ##1 state == ST_SEND);
  typing_cover_c: cover property (state == ST_TYPE && tapKey != 8'h00);
  roll_cover_c: cover property (take && sameRoll ##1 state == ST_OPS);
  mouse_cover_c: cover property (reportValid && report.kind == RPT_MOUSE && report.dx != 8'h00);
endmodule

// [verification/hid_host_model.sv]
// Host side model: accepts HID reports and keeps them in arrival order.
// Assumes the bench paces acceptance through holdOff.
`timescale 1ns/1ps
module hid_host_model (
  input  wire logic                          clock,       // System clock
  input  wire logic                          rst_n,       // Reset, active low
  input  wire key_function_pkg::hid_report_t report,      // Offered report
  input  wire logic                          reportValid, // Report offered
  input  wire logic                          holdOff,     // Stall request
  output logic                               reportReady  // Report accepted
);
  import key_function_pkg::*;
  hid_report_t got[$];
  assign reportReady = rst_n & ~holdOff;
  always @(posedge clock)
    if (rst_n && reportValid && reportReady) got.push_back(report);
endmodule

// [verification/key_function_translator_tb_top.sv]
// Self-checking bench of the key function translator.
// Assumes short tick parameters and a host model with random stalls.
`timescale 1ns/1ps
module key_function_translator_tb_top;
  import key_function_pkg::*;
  logic clock = 0, rst_n = 0, keyValid = 0, tableWe = 0, macroWe = 0, holdOff = 0;
  logic keyReady, reportValid, reportReady;
  key_event_t keyEvent = '0;
  table_write_t tableWrite = '0;
  macro_write_t macroWrite = '0;
  hid_report_t report, r;
  int errors = 0, check_count = 0, cycles = 0;
  logic [31:0] hs = 30, ps = 30;
  logic [15:0] seq[$], want[$];
  always #5 clock = ~clock;
  key_function_translator #(.TICK_CYCLES(20), .MOVE_CYCLES(8)) u_dut (.clock(clock),
    .rst_n(rst_n), .keyEvent(keyEvent), .keyValid(keyValid), .keyReady(keyReady),
    .tableWe(tableWe), .tableWrite(tableWrite), .macroWe(macroWe), .macroWrite(macroWrite),
    .report(report), .reportValid(reportValid), .reportReady(reportReady));
  hid_host_model u_host (.clock(clock), .rst_n(rst_n), .report(report),
    .reportValid(reportValid), .holdOff(holdOff), .reportReady(reportReady));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic has(input hid_report_t x, input logic [7:0] k);
    has = 1'b0;
    for (int j = 0; j < REPORT_KEYS; j++) if (x.keys[j] === k) has = 1'b1;
  endfunction
  function automatic logic [15:0] axis(input hid_report_t x, input int d);
    logic [7:0] a, o;
    a = d[1] ? x.dy : x.dx;
    o = d[1] ? x.dx : x.dy;
    if (d[0]) a = -a;
    return (o === 8'h00 && x.kind === RPT_MOUSE) ? {8'h00, a} : 16'h0000;
  endfunction
  task summarize;
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task put_entry(input logic [5:0] i, input logic [7:0] pg, input logic [7:0] fn);
    tableWrite = '{i, '{pg, fn}};
    tableWe = 1;
    tick(1);
    tableWe = 0;
  endtask
  task put_macro(input logic [4:0] m, input logic [7:0] b[$]);
    foreach (b[i]) begin
      macroWrite = '{m, 5'(i), b[i]};
      macroWe = 1;
      tick(1);
    end
    macroWe = 0;
  endtask
  task key(input logic [5:0] i, input logic p);
    int n;
    n = 0;
    keyEvent = '{p, i};
    keyValid = 1;
    while (keyReady !== 1'b1 && n < 500) begin tick(1); n++; end
    tick(1);
    keyValid = 0;
    while (keyReady !== 1'b1 && n < 500) begin tick(1); n++; end
    chk(n < 500, "key event stalled");
  endtask
  task taps;
    seq.delete();
    foreach (u_host.got[j]) if (u_host.got[j].keys[5] !== 8'h00) seq.push_back(u_host.got[j].keys[5]);
  endtask
  always @(posedge clock) begin
    cycles++;
    hs = xs(hs);
    holdOff <= #1 hs[0] & hs[1];
    if (cycles == 20000) begin errors++; summarize; end
  end
  // ==========================================================
  // Scenarios
  initial begin
    tick(10);
    rst_n = 1;
    tick(2);
    key(0, 1);
    chk(u_host.got.size() > 0 && has(u_host.got[0], 8'h04), "default key");
    key(0, 0);
    for (int i = 0; i < 33; i++) if (i < 10 || i > 30) begin
      ps = xs(ps);
      put_entry(ps[5:0], PAGE_MEDIA, 8'(i));
      u_host.got.delete();
      key(ps[5:0], 1);
      r = u_host.got[0];
      if (i == 32) chk(u_host.got.size() == 0, "media out of range");
      else chk(r.kind === RPT_CONSUMER && r.usage === ((i < 10) ? 16'(16'hB0 + i) : 16'h021F), "media");
      key(ps[5:0], 0);
    end
    put_entry(40, 8'hE1, 8'h1E);
    u_host.got.delete();
    key(40, 1);
    chk(u_host.got[0].modifiers === 8'h02 && has(u_host.got[0], 8'h1E), "combo");
    key(40, 0);
    put_macro(1, '{8'h00, 8'hE0, 8'h05, 8'h06, 8'h00, 8'h07});
    put_entry(41, PAGE_MACRO, 8'h01);
    u_host.got.delete();
    key(41, 1);
    r = u_host.got[0];
    chk(u_host.got.size() == 1 && r.modifiers === 8'h01 && has(r, 8'h05) && has(r, 8'h06) && !has(r, 8'h07), "static");
    key(41, 0);
    chk(u_host.got.size() == 2 && u_host.got[1].modifiers === 8'h00 && !has(u_host.got[1], 8'h05), "static up");
    put_macro(2, '{8'h01, 8'hE1, 8'h04, 8'h04, 8'hE9, 8'hE2, 8'h00});
    put_entry(42, PAGE_MACRO, 8'h02);
    u_host.got.delete();
    key(42, 1);
    key(42, 0);
    want = '{16'h0200, 16'h0204, 16'h0200, 16'h0204, 16'h0200, 16'h0000, 16'h0400, 16'h0000};
    chk(u_host.got.size() == 8, "typing count");
    foreach (want[j]) chk({u_host.got[j].modifiers, u_host.got[j].keys[5]} === want[j], "typing");
    put_macro(3, '{8'h02, 8'h05, 8'h04, 8'h05, 8'h00});
    put_macro(4, '{8'h02, 8'h00, 8'h06, 8'h00});
    put_entry(43, PAGE_MACRO, 8'h03);
    put_entry(44, PAGE_MACRO, 8'h04);
    u_host.got.delete();
    for (int j = 0; j < 3; j++) begin key(43, 1); key(43, 0); end
    key(44, 1);
    key(44, 0);
    tick(20);
    key(43, 1);
    key(43, 0);
    tick(150);
    taps();
    want = '{16'h04, 16'h50, 16'h4C, 16'h05, 16'h50, 16'h4C, 16'h04, 16'h50, 16'h4F, 16'h06, 16'h50, 16'h4F, 16'h04, 16'h50, 16'h4F};
    chk(seq == want, "roll sequence");
    for (int b = 0; b < 8; b++) begin
      put_entry(45, PAGE_MOUSE, 8'(8'h10 + b));
      u_host.got.delete();
      key(45, 1);
      chk(u_host.got[0].buttons === 8'(1 << b), "button");
      key(45, 0);
    end
    for (int d = 0; d < 4; d++) begin
      put_entry(46, PAGE_MOUSE, 8'(d));
      u_host.got.delete();
      key(46, 1);
      tick(60);
      key(46, 0);
      seq.delete();
      foreach (u_host.got[j]) if ((u_host.got[j].dx | u_host.got[j].dy) !== 8'h00) seq.push_back(axis(u_host.got[j], d));
      chk(seq.size() > 2 && seq[0] > 0 && seq[seq.size()-1] > seq[0], "cursor");
    end
    summarize;
  end
endmodule
